// file: hdl/packetizer_control_headers.sv
// file: header and control register block of the transmit packetizer,
// an Avalon-MM slave with waitrequest.
// assumes one clock, synchronous inputs, and that the packetizer core,
// the alternate control register and the fifos live outside this block.
`timescale 1ns/1ns

// Notes on behaviour
// - second async header quadlet, 32 bits, resets to 3fc1_0000.
// - third async header quadlet, writable, resets to zero.
// - fourth async header quadlet, writable, resets to 0008_0000.
// - isochronous header has length, tag, channel, speed and sync fields.
// - speed code 00 sends at 100 Mbit/s, 01 at 200 Mbit/s.
// - control bit 0 enables serial cycle-timer output; resets to one.
// - bit 2 sends one video test packet per isochronous cycle.
// - bit 3 sends one isochronous test packet per cycle from its header.
// - bit 4 sends one async test packet per cycle, no retries.
// - bit 18 takes quadlet count, length and increment from alternate word.
// - bit 19 is master flush enable, resets to one.
// - bit 20 flushes on cycle start while isochronous machine busy.
// - bit 21 flushes when timestamp expected but not present.
// - bit 22 resets packetizer machines and clears itself.
// - bits 23 and 24 enable cell-quadlet and test-mux writes.
// - bit 25 enables software write of format identifier.
// - bits 26 to 29 enable continuity, flag, fraction, size writes.
// - bit 30 enables source-node write, bit 31 data-length write.
// - with length enable clear the packetizer loads the data length.
// - with continuity enable clear the counter auto loads and increments.
module packetizer_control_headers #(
  parameter int unsigned ADDR_W = 9
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire logic [ADDR_W-1:0]    avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  input  wire logic                 cycle_start_i,
  input  wire logic                 isoch_idle_i,
  input  wire logic                 timestamp_expected_i,
  input  wire logic                 timestamp_present_i,
  input  wire logic [31:0]          alt_ctrl_i,
  input  wire logic                 pkt_len_valid_i,
  input  wire logic [15:0]          pkt_len_i,
  input  wire logic                 cont_load_i,
  input  wire logic [7:0]           cont_load_val_i,
  input  wire logic                 pkt_sent_i,
  input  wire logic [7:0]           block_inc_i,
  input  wire logic                 test_data_take_i,
  output logic      [31:0]          async_hdr_quad_second_o,
  output logic      [31:0]          async_hdr_quad_third_o,
  output logic      [31:0]          async_hdr_quad_fourth_o,
  output logic      [31:0]          isoch_tx_header_o,
  output logic      [31:0]          packetizer_control_o,
  output logic                      isoch_speed_200_o,
  output pktz_pkg::test_req_t       test_req_o,
  output logic                      async_no_retry_o,
  output logic      [31:0]          test_count_o,
  output pktz_pkg::alt_ctrl_t       alt_ctrl_o,
  output logic                      alt_ctrl_valid_o,
  output logic                      flush_o,
  output logic                      packetizer_soft_reset_o,
  output logic      [15:0]          video_len_o,
  output logic      [7:0]           block_continuity_count_o
);

  initial begin
    if (ADDR_W < 9 || ADDR_W > 16) begin
      $error("ADDR_W must be 9 to 16");
    end
  end

  typedef struct packed {
    logic                wait_r;
    logic [31:0]         rdata;
    logic [31:0]         async2;
    logic [31:0]         async3;
    logic [31:0]         async4;
    logic [31:0]         isoch;
    logic [31:0]         ctl;
    logic                spd200;
    pktz_pkg::test_req_t req;
    logic                no_retry;
    logic [31:0]         tcount;
    pktz_pkg::alt_ctrl_t alt;
    logic                alt_valid;
    logic                flush;
    logic [15:0]         vlen;
    logic [7:0]          dbc;
  } state_t;

  localparam state_t ST_RESET = '{
    wait_r:    1'b1,
    rdata:     32'h0000_0000,
    async2:    pktz_pkg::RST_ASYNC_SECOND,
    async3:    pktz_pkg::RST_ASYNC_THIRD,
    async4:    pktz_pkg::RST_ASYNC_FOURTH,
    isoch:     pktz_pkg::RST_ISOCH_HDR,
    ctl:       pktz_pkg::RST_CONTROL,
    spd200:    1'b0,
    req:       '0,
    no_retry:  1'b0,
    tcount:    32'h0000_0000,
    alt:       '0,
    alt_valid: 1'b0,
    flush:     1'b0,
    vlen:      16'h0000,
    dbc:       8'h00
  };

  state_t st_r;
  state_t st_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  logic [8:0]  addr;
  logic        req;
  logic        commit_wr;
  logic [31:0] ctl_eff;

  assign addr      = avs_address_i[8:0];
  assign req       = avs_read_i | avs_write_i;
  // a write lands only at the edge where waitrequest is seen low
  assign commit_wr = avs_write_i & ~st_r.wait_r;

  always_comb begin
    st_nxt = st_r;
    // one wait cycle, then a single low cycle that completes the transfer
    st_nxt.wait_r = ~(req & st_r.wait_r);
    if (req & st_r.wait_r) begin
      unique case (addr)
        pktz_pkg::OFS_ASYNC_HDR_QUAD_SECOND: st_nxt.rdata = st_r.async2;
        pktz_pkg::OFS_ASYNC_HDR_QUAD_THIRD:  st_nxt.rdata = st_r.async3;
        pktz_pkg::OFS_ASYNC_HDR_QUAD_FOURTH: st_nxt.rdata = st_r.async4;
        pktz_pkg::OFS_ISOCH_TX_HEADER:       st_nxt.rdata = st_r.isoch;
        pktz_pkg::OFS_PACKETIZER_CONTROL:    st_nxt.rdata = st_r.ctl;
        default:                             st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // soft reset bit lives one cycle only
    st_nxt.ctl[pktz_pkg::CTL_SOFT_RST] = 1'b0;
    if (commit_wr) begin
      unique case (addr)
        pktz_pkg::OFS_ASYNC_HDR_QUAD_SECOND:
          st_nxt.async2 = merge(st_r.async2, avs_writedata_i, avs_byteenable_i, '1);
        pktz_pkg::OFS_ASYNC_HDR_QUAD_THIRD:
          st_nxt.async3 = merge(st_r.async3, avs_writedata_i, avs_byteenable_i, '1);
        pktz_pkg::OFS_ASYNC_HDR_QUAD_FOURTH:
          st_nxt.async4 = merge(st_r.async4, avs_writedata_i, avs_byteenable_i, '1);
        pktz_pkg::OFS_ISOCH_TX_HEADER:
          st_nxt.isoch = merge(st_r.isoch, avs_writedata_i, avs_byteenable_i,
                               pktz_pkg::MASK_ISOCH_HDR);
        pktz_pkg::OFS_PACKETIZER_CONTROL:
          st_nxt.ctl = merge(st_r.ctl, avs_writedata_i, avs_byteenable_i,
                             pktz_pkg::MASK_CONTROL);
        default: ;
      endcase
    end
    ctl_eff = st_r.ctl;
    st_nxt.spd200 = st_r.isoch[pktz_pkg::ISO_SPD_LSB +: 2] == pktz_pkg::SPD_CODE_200;
    st_nxt.no_retry = ctl_eff[pktz_pkg::CTL_ASY_TEST];
    // one request per enabled class at each cycle start
    st_nxt.req.vid = cycle_start_i & ctl_eff[pktz_pkg::CTL_VID_TEST];
    st_nxt.req.iso = cycle_start_i & ctl_eff[pktz_pkg::CTL_ISO_TEST];
    st_nxt.req.asy = cycle_start_i & ctl_eff[pktz_pkg::CTL_ASY_TEST];
    if (test_data_take_i) begin
      st_nxt.tcount = st_r.tcount + 32'h0000_0001;
    end
    st_nxt.alt_valid = ctl_eff[pktz_pkg::CTL_ALT_SEL];
    st_nxt.alt.quads = {4'h0, alt_ctrl_i[pktz_pkg::ALT_QUAD_LSB +: 8]};
    st_nxt.alt.len   = alt_ctrl_i[pktz_pkg::ALT_LEN_LSB +: 16];
    st_nxt.alt.inc   = alt_ctrl_i[pktz_pkg::ALT_INC_LSB +: 8];
    st_nxt.flush = ctl_eff[pktz_pkg::CTL_FLUSH_MST] & (
      (ctl_eff[pktz_pkg::CTL_FLUSH_CYC] & cycle_start_i & ~isoch_idle_i) |
      (ctl_eff[pktz_pkg::CTL_FLUSH_TS] & timestamp_expected_i & ~timestamp_present_i));
    if (!ctl_eff[pktz_pkg::CTL_LEN_WEN] && pkt_len_valid_i) begin
      st_nxt.vlen = pkt_len_i;
    end
    // bus reset has no path here, so the counter survives it
    if (!ctl_eff[pktz_pkg::CTL_DBC_WEN]) begin
      if (cont_load_i) begin
        st_nxt.dbc = cont_load_val_i;
      end else if (pkt_sent_i) begin
        st_nxt.dbc = st_r.dbc + (ctl_eff[pktz_pkg::CTL_ALT_SEL] ?
                                 st_r.alt.inc : block_inc_i);
      end
    end
    // packetizer soft reset drops pending test requests and the test data count; the continuity counter keeps its value
    if (ctl_eff[pktz_pkg::CTL_SOFT_RST]) begin
      st_nxt.req    = '0;
      st_nxt.tcount = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= ST_RESET;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_o          = st_r.rdata;
  assign avs_waitrequest_o       = st_r.wait_r;
  assign async_hdr_quad_second_o = st_r.async2;
  assign async_hdr_quad_third_o  = st_r.async3;
  assign async_hdr_quad_fourth_o = st_r.async4;
  assign isoch_tx_header_o       = st_r.isoch;
  assign packetizer_control_o    = st_r.ctl;
  assign isoch_speed_200_o       = st_r.spd200;
  assign test_req_o              = st_r.req;
  assign async_no_retry_o        = st_r.no_retry;
  assign test_count_o            = st_r.tcount;
  assign alt_ctrl_o              = st_r.alt;
  assign alt_ctrl_valid_o        = st_r.alt_valid;
  assign flush_o                 = st_r.flush;
  assign packetizer_soft_reset_o = st_r.ctl[pktz_pkg::CTL_SOFT_RST];
  assign video_len_o             = st_r.vlen;
  assign block_continuity_count_o = st_r.dbc;

endmodule // packetizer_control_headers

// file: hdl/pktz_pkg.sv
// package: register map, field positions and reset values of the packetizer
// header and control registers.
// assumes bit 0 of each 32-bit register is its most significant bit, so
// documented bit n sits at vector index 31-n.
package pktz_pkg;

  // byte addresses on the register bus
  localparam logic [8:0] OFS_ASYNC_HDR_QUAD_SECOND = 9'h1b4;
  localparam logic [8:0] OFS_ASYNC_HDR_QUAD_THIRD  = 9'h1b8;
  localparam logic [8:0] OFS_ASYNC_HDR_QUAD_FOURTH = 9'h1bc;
  localparam logic [8:0] OFS_ISOCH_TX_HEADER       = 9'h1c0;
  localparam logic [8:0] OFS_PACKETIZER_CONTROL    = 9'h1c4;

  // reset values
  localparam logic [31:0] RST_ASYNC_SECOND = 32'h3fc1_0000;
  localparam logic [31:0] RST_ASYNC_THIRD  = 32'h0000_0000;
  localparam logic [31:0] RST_ASYNC_FOURTH = 32'h0008_0000;
  localparam logic [31:0] RST_ISOCH_HDR    = 32'h0000_0000;
  localparam logic [31:0] RST_CONTROL      = 32'h8000_1c00;

  // writable bits; the rest are reserved and read as zero
  localparam logic [31:0] MASK_ISOCH_HDR = 32'hffff_ff3f;
  localparam logic [31:0] MASK_CONTROL   = 32'hb800_3fff;

  // isochronous header fields (vector indices)
  localparam int unsigned ISO_LEN_LSB   = 16;
  localparam int unsigned ISO_SPD_LSB   = 4;
  localparam logic [1:0]  SPD_CODE_100  = 2'h0;
  localparam logic [1:0]  SPD_CODE_200  = 2'h1;

  // packetizer control fields (vector index = 31 - documented bit)
  localparam int unsigned CTL_CYCLE_SER  = 31;
  localparam int unsigned CTL_VID_TEST   = 29;
  localparam int unsigned CTL_ISO_TEST   = 28;
  localparam int unsigned CTL_ASY_TEST   = 27;
  localparam int unsigned CTL_ALT_SEL    = 13;
  localparam int unsigned CTL_FLUSH_MST  = 12;
  localparam int unsigned CTL_FLUSH_CYC  = 11;
  localparam int unsigned CTL_FLUSH_TS   = 10;
  localparam int unsigned CTL_SOFT_RST   = 9;
  localparam int unsigned CTL_QPC_WEN    = 8;
  localparam int unsigned CTL_MUX_WEN    = 7;
  localparam int unsigned CTL_FMT_WEN    = 6;
  localparam int unsigned CTL_DBC_WEN    = 5;
  localparam int unsigned CTL_SPH_WEN    = 4;
  localparam int unsigned CTL_FN_WEN     = 3;
  localparam int unsigned CTL_DBS_WEN    = 2;
  localparam int unsigned CTL_SID_WEN    = 1;
  localparam int unsigned CTL_LEN_WEN    = 0;

  // alternate control word fields (vector indices)
  localparam int unsigned ALT_QUAD_LSB = 24;
  localparam int unsigned ALT_LEN_LSB  = 8;
  localparam int unsigned ALT_INC_LSB  = 0;

  typedef struct packed {
    logic [11:0] quads;
    logic [15:0] len;
    logic [7:0]  inc;
  } alt_ctrl_t;

  typedef struct packed {
    logic vid;
    logic iso;
    logic asy;
  } test_req_t;

endpackage

// file: sim/packetizer_control_headers_bench.sv
// testbench: register map, control bits and side outputs of the block
// assumes the host model for bus cycles; clock enable held high
`timescale 1ns/1ns
module packetizer_control_headers_bench;
  logic clk_i = 0, sys_rst_i = 1, cyc = 0, idle = 1, tse = 0, len_v = 0, ld = 0, sent = 0;
  logic [15:0] plen = '0;
  logic [7:0]  ldv = '0, binc = '0;
  logic [31:0] alt = '0, rdat, ctl;
  logic [8:0]  adr;
  logic        rd, wr, wt, spd, nrty, altv, fl, srst, seen = 0, take = 0;
  logic [31:0] tcnt;
  logic [31:0] wdat;
  logic [15:0] vlen;
  logic [7:0]  dbc;
  pktz_pkg::test_req_t treq;
  pktz_pkg::alt_ctrl_t altc;
  int failures = 0, cmp_count = 0;
  localparam logic [31:0] RC = pktz_pkg::RST_CONTROL;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (srst === 1'b1) seen <= 1'b1;
  packetizer_control_headers packetizer_control_headers_inst (.clk_i, .sys_rst_i, .ce_i(1'b1),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .cycle_start_i(cyc), .isoch_idle_i(idle), .timestamp_expected_i(tse),
    .timestamp_present_i(1'b0), .alt_ctrl_i(alt), .pkt_len_valid_i(len_v), .pkt_len_i(plen),
    .cont_load_i(ld), .cont_load_val_i(ldv), .pkt_sent_i(sent), .block_inc_i(binc),
    .test_data_take_i(take), .async_hdr_quad_second_o(), .async_hdr_quad_third_o(),
    .async_hdr_quad_fourth_o(), .isoch_tx_header_o(), .packetizer_control_o(ctl),
    .isoch_speed_200_o(spd), .test_req_o(treq), .async_no_retry_o(nrty), .test_count_o(tcnt),
    .alt_ctrl_o(altc), .alt_ctrl_valid_o(altv), .flush_o(fl),
    .packetizer_soft_reset_o(srst), .video_len_o(vlen), .block_continuity_count_o(dbc));
  pktz_host pktz_host_inst (.clk_i, .avs_waitrequest_i(wt), .avs_readdata_i(rdat),
    .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr), .avs_writedata_o(wdat));
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wrr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    pktz_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] q;
    pktz_host_inst.xfer(1'b0, a, '0, q);
    chk("readdata", q, e);
  endtask
  // wait for an edge, then settle 1 ns past it before checking
  task automatic look(); @(posedge clk_i); #1; endtask
  task automatic t_map();
    logic [31:0] m[6] = '{'1, '1, '1, pktz_pkg::MASK_ISOCH_HDR, pktz_pkg::MASK_CONTROL, '0};
    logic [31:0] p;
    rdc(9'h1b4, 32'h3fc1_0000);
    rdc(9'h1b8, 32'h0);
    rdc(9'h1bc, 32'h0008_0000);
    rdc(9'h1c4, RC);
    for (int k = 0; k < 2; k++) begin
      p = k ? 32'h0 : 32'hffff_fdff;
      for (int i = 0; i < 6; i++) wrr(9'h1b4 + 9'(4 * i), p);
      for (int i = 0; i < 6; i++) rdc(9'h1b4 + 9'(4 * i), p & m[i]);
    end
  endtask
  task automatic t_side();
    wrr(9'h1c0, 32'h10);
    look(); chk("speed", spd, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i); wrr(9'h1c4, RC | (32'h1 << (29 - i)));
      cyc <= 1'b1; @(posedge clk_i); cyc <= 1'b0; #1;
      chk("test_req", treq, 3'b100 >> i);
      chk("no_retry", nrty, i == 2);
    end
    @(posedge clk_i); wrr(9'h1c4, RC);
    idle <= 1'b0; cyc <= 1'b1; @(posedge clk_i); cyc <= 1'b0; idle <= 1'b1; #1;
    chk("flush_cycle", fl, 1'b1);
    @(posedge clk_i); tse <= 1'b1; @(posedge clk_i); tse <= 1'b0; #1;
    chk("flush_ts", fl, 1'b1);
    @(posedge clk_i); wrr(9'h1c4, RC & ~32'h1000);
    idle <= 1'b0; cyc <= 1'b1; @(posedge clk_i); cyc <= 1'b0; idle <= 1'b1; #1;
    chk("flush_off", fl, 1'b0);
  endtask
  task automatic t_ctl();
    @(posedge clk_i); take <= 1'b1;
    repeat (3) @(posedge clk_i);
    take <= 1'b0; #1;
    chk("count", tcnt, 32'h3);
    @(posedge clk_i); wrr(9'h1c4, RC | 32'h200);
    repeat (3) @(posedge clk_i);
    chk("soft_reset", seen, 1'b1);
    chk("count_clr", tcnt, 32'h0);
    rdc(9'h1c4, RC);
    alt <= 32'h1234_5678; wrr(9'h1c4, RC | 32'h2000);
    look(); chk("alt", {altv, altc}, {1'b1, 12'h012, 16'h3456, 8'h78});
    @(posedge clk_i); wrr(9'h1c4, RC);
    plen <= 16'h0abc; len_v <= 1'b1; ldv <= 8'h40; ld <= 1'b1;
    @(posedge clk_i); len_v <= 1'b0; ld <= 1'b0; binc <= 8'h03; sent <= 1'b1;
    @(posedge clk_i); sent <= 1'b0; #1;
    chk("cont", dbc, 8'h43);
    chk("len", vlen, 16'h0abc);
    @(posedge clk_i); wrr(9'h1c4, RC | 32'h1);
    plen <= 16'h1111; len_v <= 1'b1; @(posedge clk_i); len_v <= 1'b0;
    look(); chk("len_locked", vlen, 16'h0abc);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_map();
    t_side();
    t_ctl();
    final_report();
  end
  initial begin
    #100000;
    failures++;
    final_report();
  end
endmodule // packetizer_control_headers_bench

// file: sim/packetizer_control_headers_props.sv
// checker: timing of the packetizer side outputs against their causes
// assumes control vector bit = 31 - documented bit
`timescale 1ns/1ns
module pktz_props (
  input wire logic                clk_i,
  input wire logic                sys_rst_i,
  input wire logic                ce_i,
  input wire logic                cycle_start_i,
  input wire logic                isoch_idle_i,
  input wire logic                timestamp_expected_i,
  input wire logic                timestamp_present_i,
  input wire logic                pkt_len_valid_i,
  input wire logic [15:0]         pkt_len_i,
  input wire logic                cont_load_i,
  input wire logic [7:0]          cont_load_val_i,
  input wire logic [31:0]         packetizer_control_o,
  input wire pktz_pkg::test_req_t test_req_o,
  input wire logic                flush_o,
  input wire logic                packetizer_soft_reset_o,
  input wire logic [15:0]         video_len_o,
  input wire logic [7:0]          block_continuity_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic [31:0] c = packetizer_control_o;
  wire logic        go = ce_i && cycle_start_i && !packetizer_soft_reset_o;
  property p_vid; go && c[29] |=> test_req_o.vid; endproperty
  a_vid: assert property (p_vid) else $error("video test request missing");
  property p_iso; go && c[28] |=> test_req_o.iso; endproperty
  a_iso: assert property (p_iso) else $error("isoch test request missing");
  property p_asy; go && c[27] |=> test_req_o.asy; endproperty
  a_asy: assert property (p_asy) else $error("async test request missing");
  property p_mst; !c[12] |=> !flush_o; endproperty
  a_mst: assert property (p_mst) else $error("flush without master enable");
  property p_cyc; ce_i && cycle_start_i && !isoch_idle_i && c[12] && c[11] |=> flush_o; endproperty
  a_cyc: assert property (p_cyc) else $error("busy cycle start not flushed");
  property p_ts; ce_i && timestamp_expected_i && !timestamp_present_i && c[12] && c[10]
    |=> flush_o; endproperty
  a_ts: assert property (p_ts) else $error("missing timestamp not flushed");
  property p_srst; ce_i && c[9] |=> !c[9] && !packetizer_soft_reset_o; endproperty
  a_srst: assert property (p_srst) else $error("soft reset did not clear");
  property p_len; ce_i && pkt_len_valid_i && !c[0] |=> video_len_o == $past(pkt_len_i);
  endproperty
  a_len: assert property (p_len) else $error("length load lost");
  property p_dbc; ce_i && cont_load_i && !c[5] |=>
    block_continuity_count_o == $past(cont_load_val_i); endproperty
  a_dbc: assert property (p_dbc) else $error("continuity load lost");
endmodule // pktz_props
bind packetizer_control_headers pktz_props pktz_props_inst (.clk_i, .sys_rst_i, .ce_i,
  .cycle_start_i, .isoch_idle_i, .timestamp_expected_i, .timestamp_present_i,
  .pkt_len_valid_i, .pkt_len_i, .cont_load_i, .cont_load_val_i, .packetizer_control_o,
  .test_req_o, .flush_o, .packetizer_soft_reset_o, .video_len_o, .block_continuity_count_o);

// file: sim/pktz_host.sv
// host model: avalon master reading and writing the packetizer registers
// assumes one clock; the slave answers with waitrequest low
`timescale 1ns/1ns
module pktz_host (
  input  wire logic        clk_i,
  input  wire logic        avs_waitrequest_i,
  input  wire logic [31:0] avs_readdata_i,
  output logic      [8:0]  avs_address_o,
  output logic             avs_read_o,
  output logic             avs_write_o,
  output logic      [31:0] avs_writedata_o
);
  initial {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o} = '0;
  // one access; ends one edge after release so calls never collide
  // no local limit: a slave that never answers is caught by the bench watchdog
  task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_write_o <= w;
    avs_read_o <= !w;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule // pktz_host
